// ===== core/brkm_params.svh
// Break module offsets, field positions, reset values and constants
`ifndef BRKM_PARAMS_SVH
`define BRKM_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BRKM_OFS_STATUS_CONTROL 8'h00
`define BRKM_OFS_ADDRESS_HIGH 8'h04
`define BRKM_OFS_ADDRESS_LOW 8'h08
`define BRKM_OFS_AUXILIARY 8'h0C
`define BRKM_OFS_WAIT_STATUS 8'h10
`define BRKM_OFS_FLAG_CONTROL 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BRKM_BIT_ENABLE 7
`define BRKM_BIT_ACTIVE 6
`define BRKM_BIT_WDOG_DISABLE 0
`define BRKM_BIT_WAIT_EXIT 1
`define BRKM_BIT_CLEAR_FLAG 7

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define BRKM_RST_BYTE 8'h00
`define BRKM_RST_ADDR 16'h0000
`define BRKM_SWI_OPCODE 8'h83
`define BRKM_VEC_NORMAL 16'hFFFC
`define BRKM_VEC_MONITOR 16'hFEFC
`define BRKM_RESP_OKAY 2'h0
`define BRKM_RESP_SLVERR 2'h2

`endif

// ===== core/brkm_pkg.sv
// Break module shared types
package brkm_pkg;
    typedef enum logic [1:0] {
        BRKM_IDLE = 2'b00,
        BRKM_PEND = 2'b01,
        BRKM_BREAK = 2'b10
    } brkm_state_e;

    // CPU bus cycle as seen by the break logic
    typedef struct packed {
        logic valid;
        logic cpu_gen;
        logic opcode;
        logic [15:0] addr;
    } brkm_cpu_cyc_s;

    // Hooks toward the system integration logic
    typedef struct packed {
        logic breakpoint_request;
        logic load_swi;
        logic [7:0] swi_opcode;
        logic [15:0] vector_addr;
        logic timer_halt;
        logic watchdog_disable;
        logic flag_clear_allow;
        logic in_break;
    } brkm_sil_s;
endpackage : brkm_pkg

// ===== core/brkm_addr_match.sv
// Registered 16-bit comparator of the CPU fetch address
`timescale 1ns/1ps
module brkm_addr_match
    import brkm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Compare inputs
    input wire brkm_cpu_cyc_s cyc,
    input wire logic [15:0] break_addr,
    input wire logic enable,
    // Result
    output logic hit_ff,
    output logic hit_opcode_ff
);
    wire logic nxt_hit;
    // Only valid CPU cycles count; low-power modes give none
    assign nxt_hit = enable && cyc.valid && cyc.cpu_gen && (cyc.addr == break_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_ff <= 1'b0;
            hit_opcode_ff <= 1'b0;
        end else begin
            hit_ff <= nxt_hit;
            hit_opcode_ff <= nxt_hit && cyc.opcode;
        end
    end
endmodule : brkm_addr_match

// ===== core/brkm_top.sv
// Breakpoint and break-interrupt unit with AXI4-Lite registers
//
// Behaviour
// - With break enable set, request break when CPU address equals break address.
// - Break loads the SOFTWARE_INTERRUPT_OPCODE opcode; vector FFFC, or FEFC in monitor mode.
// - Software writing one to break-active forces a break without a match.
// - Return-from-interrupt inside the handler ends the break state.
// - Match on an opcode address: that instruction waits for the handler.
// - Match on an operand address: instruction completes before the break.
// - Software break is taken just before the next instruction.
// - Cleared active with unchanged address suppresses the repeat break.
// - Match sets break-active, reset clears it; software clears it in handler.
// - Break enable is bit 7 of status/control; cleared by write zero and reset.
// - Two byte registers hold break address halves; reset clears both.
// - Timer counter halts while a break is in progress.
// - Watchdog disabled in break in monitor mode when its disable bit is set.
// - Flag clears in other modules allowed in break only with clear-enable bit.
// - Wait-exit flag reads one when wait ended by break, else zero.
// - Break stays enabled in wait/stop, but no address match occurs there.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "brkm_params.svh"
module brkm_top
    import brkm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU core
    input wire brkm_cpu_cyc_s cpu_cyc,
    input wire logic insn_boundary,
    input wire logic rti_exec,
    input wire logic wait_mode,
    input wire logic monitor_mode,
    // System integration logic
    output brkm_sil_s sil
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] brk_addr_hi_ff;
    logic [7:0] brk_addr_lo_ff;
    logic break_enable_bit_ff;
    logic break_active_bit_ff;
    logic break_watchdog_disable_bit_ff;
    logic break_clear_flag_enable_bit_ff;
    logic wait_exit_by_break_flag_ff;
    logic armed_ff;
    logic sw_req_ff;
    brkm_state_e state_ff;
    brkm_state_e nxt_state;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [7:0] rdata_ff;
    logic rerr_ff;
    logic berr_ff;

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic [7:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire logic [7:0] wr_byte = w_held_ff ? wdata_ff : s_axi_wdata[7:0];
    wire logic wr_lane = w_held_ff ? wlane_ff : s_axi_wstrb[0];
    wire logic aw_have = aw_held_ff || s_axi_awvalid;
    wire logic w_have = w_held_ff || s_axi_wvalid;
    wire logic wr_fire = aw_have && w_have && !bvalid_ff;
    wire logic wr_en = wr_fire && wr_lane;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = berr_ff ? `BRKM_RESP_SLVERR : `BRKM_RESP_OKAY;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = {24'h000000, rdata_ff};
    assign s_axi_rresp = rerr_ff ? `BRKM_RESP_SLVERR : `BRKM_RESP_OKAY;

    wire logic wr_sc = wr_en && (wr_addr == `BRKM_OFS_STATUS_CONTROL);
    wire logic wr_hi = wr_en && (wr_addr == `BRKM_OFS_ADDRESS_HIGH);
    wire logic wr_lo = wr_en && (wr_addr == `BRKM_OFS_ADDRESS_LOW);
    wire logic wr_aux = wr_en && (wr_addr == `BRKM_OFS_AUXILIARY);
    wire logic wr_ws = wr_en && (wr_addr == `BRKM_OFS_WAIT_STATUS);
    wire logic wr_fc = wr_en && (wr_addr == `BRKM_OFS_FLAG_CONTROL);
    wire logic wr_mapped = (wr_addr == `BRKM_OFS_STATUS_CONTROL) || (wr_addr == `BRKM_OFS_ADDRESS_HIGH)
        || (wr_addr == `BRKM_OFS_ADDRESS_LOW) || (wr_addr == `BRKM_OFS_AUXILIARY)
        || (wr_addr == `BRKM_OFS_WAIT_STATUS) || (wr_addr == `BRKM_OFS_FLAG_CONTROL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            berr_ff <= 1'b0;
        end else begin
            // Hold whichever channel arrives first until the other comes
            aw_held_ff <= wr_fire ? 1'b0 : (aw_held_ff || aw_take);
            w_held_ff <= wr_fire ? 1'b0 : (w_held_ff || w_take);
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                berr_ff <= !wr_mapped;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire logic [7:0] sc_val = {break_enable_bit_ff, break_active_bit_ff, 6'h00};
    wire logic [7:0] aux_val = {7'h00, break_watchdog_disable_bit_ff};
    wire logic [7:0] ws_val = {6'h00, wait_exit_by_break_flag_ff, 1'b0};
    wire logic [7:0] fc_val = {break_clear_flag_enable_bit_ff, 7'h00};
    wire logic rd_take = s_axi_arvalid && !rvalid_ff;
    wire logic [8:0] rd_sel =
        (s_axi_araddr == `BRKM_OFS_STATUS_CONTROL) ? {1'b0, sc_val} :
        (s_axi_araddr == `BRKM_OFS_ADDRESS_HIGH) ? {1'b0, brk_addr_hi_ff} :
        (s_axi_araddr == `BRKM_OFS_ADDRESS_LOW) ? {1'b0, brk_addr_lo_ff} :
        (s_axi_araddr == `BRKM_OFS_AUXILIARY) ? {1'b0, aux_val} :
        (s_axi_araddr == `BRKM_OFS_WAIT_STATUS) ? {1'b0, ws_val} :
        (s_axi_araddr == `BRKM_OFS_FLAG_CONTROL) ? {1'b0, fc_val} : 9'h100;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= `BRKM_RST_BYTE;
            rerr_ff <= 1'b0;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_sel[7:0];
            rerr_ff <= rd_sel[8];
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Address compare
    // ----------------------------------------
    wire logic [15:0] break_addr = {brk_addr_hi_ff, brk_addr_lo_ff};
    wire logic hit;
    wire logic hit_opcode;

    brkm_addr_match u_match (
        .aclk(aclk),
        .aresetn(aresetn),
        .cyc(cpu_cyc),
        .break_addr(break_addr),
        .enable(break_enable_bit_ff && armed_ff && (state_ff == BRKM_IDLE)),
        .hit_ff(hit),
        .hit_opcode_ff(hit_opcode)
    );

    // ----------------------------------------
    // Break sequencing
    // ----------------------------------------
    // Opcode hits break before that opcode runs; operand hits wait for the boundary
    wire logic sw_set = wr_sc && wr_byte[`BRKM_BIT_ACTIVE];
    wire logic take_now = (hit && hit_opcode) || ((sw_req_ff || hit) && insn_boundary);
    wire logic leave = (state_ff == BRKM_BREAK) && rti_exec;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BRKM_IDLE: begin
                if (take_now) begin
                    nxt_state = BRKM_BREAK;
                end else if (hit || sw_set) begin
                    nxt_state = BRKM_PEND;
                end
            end
            BRKM_PEND: begin
                if (insn_boundary || (hit && hit_opcode)) begin
                    nxt_state = BRKM_BREAK;
                end
            end
            BRKM_BREAK: begin
                if (rti_exec) begin
                    nxt_state = BRKM_IDLE;
                end
            end
            default: begin
                nxt_state = BRKM_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= BRKM_IDLE;
            sw_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sw_req_ff <= (nxt_state == BRKM_PEND);
        end
    end

    // ----------------------------------------
    // Control and status bits
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_addr_hi_ff <= `BRKM_RST_BYTE;
            brk_addr_lo_ff <= `BRKM_RST_BYTE;
            break_enable_bit_ff <= 1'b0;
            break_active_bit_ff <= 1'b0;
            break_watchdog_disable_bit_ff <= 1'b0;
            break_clear_flag_enable_bit_ff <= 1'b0;
            armed_ff <= 1'b1;
        end else begin
            if (wr_hi) begin
                brk_addr_hi_ff <= wr_byte;
            end
            if (wr_lo) begin
                brk_addr_lo_ff <= wr_byte;
            end
            if (wr_sc) begin
                break_enable_bit_ff <= wr_byte[`BRKM_BIT_ENABLE];
            end
            // Hit sets win over a same-cycle software clear
            if (hit || sw_set) begin
                break_active_bit_ff <= 1'b1;
            end else if (wr_sc) begin
                break_active_bit_ff <= 1'b0;
            end
            // Re-arm on any write to an address register; stops a repeat on the same spot
            if (wr_hi || wr_lo) begin
                armed_ff <= 1'b1;
            end else if (hit) begin
                armed_ff <= 1'b0;
            end
            if (wr_aux) begin
                break_watchdog_disable_bit_ff <= wr_byte[`BRKM_BIT_WDOG_DISABLE];
            end
            if (wr_fc) begin
                break_clear_flag_enable_bit_ff <= wr_byte[`BRKM_BIT_CLEAR_FLAG];
            end
        end
    end

    // Wait-exit flag: set on a break taken in wait, cleared by writing zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_exit_by_break_flag_ff <= 1'b0;
        end else if (wait_mode && (nxt_state == BRKM_BREAK) && (state_ff != BRKM_BREAK)) begin
            wait_exit_by_break_flag_ff <= 1'b1;
        end else if (wr_ws && !wr_byte[`BRKM_BIT_WAIT_EXIT]) begin
            wait_exit_by_break_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs toward integration logic
    // ----------------------------------------
    wire logic in_break = (state_ff == BRKM_BREAK);
    assign sil.breakpoint_request = (state_ff != BRKM_BREAK) && (nxt_state == BRKM_BREAK);
    assign sil.load_swi = sil.breakpoint_request;
    assign sil.swi_opcode = `BRKM_SWI_OPCODE;
    assign sil.vector_addr = monitor_mode ? `BRKM_VEC_MONITOR : `BRKM_VEC_NORMAL;
    assign sil.timer_halt = in_break;
    assign sil.watchdog_disable = in_break && monitor_mode && break_watchdog_disable_bit_ff;
    assign sil.flag_clear_allow = !in_break || break_clear_flag_enable_bit_ff;
    assign sil.in_break = in_break;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    opcode_hit_break_a: assert property (hit && hit_opcode |=> state_ff == BRKM_BREAK)
        else $error("opcode hit did not enter break");
    rti_ends_break_a: assert property (in_break && rti_exec |=> state_ff == BRKM_IDLE)
        else $error("return did not end break");
    timer_halt_a: assert property (sil.breakpoint_request |=> sil.timer_halt && sil.in_break)
        else $error("timer halt mismatch");
    sw_break_pend_a: assert property ((state_ff == BRKM_IDLE) && sw_set && !take_now
        |=> state_ff == BRKM_PEND)
        else $error("software break lost");
    pend_boundary_a: assert property ((state_ff == BRKM_PEND) && insn_boundary |=> in_break)
        else $error("pending break not taken at boundary");
    active_set_a: assert property (hit |=> break_active_bit_ff)
        else $error("active bit not set on match");
    no_repeat_a: assert property (hit && !wr_hi && !wr_lo |=> !armed_ff)
        else $error("match did not disarm");
    wdog_gate_a: assert property (sil.watchdog_disable |-> monitor_mode && in_break)
        else $error("watchdog disabled outside monitor break");
    flag_block_a: assert property (sil.breakpoint_request && !break_clear_flag_enable_bit_ff && !wr_fc
        |=> !sil.flag_clear_allow)
        else $error("flag clear allowed in break");
    vector_sel_a: assert property (monitor_mode |-> sil.vector_addr == `BRKM_VEC_MONITOR)
        else $error("wrong vector in monitor mode");

    cov_addr_break_c: cover property (hit ##[1:8] in_break ##[1:20] !in_break);
    cov_sw_break_c: cover property (sw_set ##1 state_ff == BRKM_PEND ##[1:8] in_break);
    cov_wait_exit_c: cover property (wait_mode && sil.breakpoint_request);
endmodule : brkm_top

// ===== sim/brkm_cpu_model.sv
// CPU core and system integration model facing the break unit
`timescale 1ns/1ps
module brkm_cpu_model
    import brkm_pkg::*;
#(
    parameter int HANDLER_CYCLES = 40
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench control
    input wire logic run,
    input wire logic load_pc,
    input wire logic [15:0] start_pc,
    input wire logic wait_mode,
    // Break unit
    input wire brkm_sil_s sil,
    output brkm_cpu_cyc_s cpu_cyc,
    output logic insn_boundary,
    output logic rti_exec
);
    // ----------------------------------------
    // Fetch and handler sequencing
    // ----------------------------------------
    logic [15:0] pc_ff;
    logic [7:0] hcnt_ff;
    wire fetch_on = run && !load_pc && !wait_mode && !sil.in_break && !sil.load_swi;

    // Two-byte instructions: even bytes are opcodes; a released bus shows the inverse address
    assign cpu_cyc = '{valid: fetch_on, cpu_gen: 1'b1, opcode: ~pc_ff[0], addr: fetch_on ? pc_ff : ~pc_ff};
    // Parked in wait the CPU sits at an instruction boundary
    // Kept free of the break request so no zero-delay loop forms through the break unit
    assign insn_boundary = run && !load_pc && !sil.in_break && (wait_mode || ~pc_ff[0]);
    assign rti_exec = sil.in_break && (hcnt_ff == 8'(HANDLER_CYCLES));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_ff <= 16'h0000;
            hcnt_ff <= 8'h00;
        end else begin
            pc_ff <= load_pc ? start_pc : (fetch_on ? pc_ff + 16'h0001 : pc_ff);
            hcnt_ff <= sil.in_break ? hcnt_ff + 8'h01 : 8'h00;
        end
    end
endmodule : brkm_cpu_model

// ===== sim/tb_top.sv
// Self-checking bench for the break unit
`timescale 1ns/1ps
module tb_top;
    import brkm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    brkm_cpu_cyc_s cpu_cyc;
    brkm_sil_s sil;
    logic insn_boundary, rti_exec;
    logic wait_mode = 1'b0, monitor_mode = 1'b0, run = 1'b0, load_pc = 1'b0;
    logic [15:0] start_pc = 16'h0000;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic [1:0] wr_resp;
    int n_req = 0;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    always #2.5 aclk = ~aclk;

    brkm_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_cyc, .insn_boundary,
        .rti_exec, .wait_mode, .monitor_mode, .sil);

    brkm_cpu_model #(.HANDLER_CYCLES(40)) cpu (.aclk, .aresetn, .run, .load_pc, .start_pc, .wait_mode, .sil,
        .cpu_cyc, .insn_boundary, .rti_exec);

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Whole run is well under this many cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Every break is announced by one request pulse with the opcode load
    always @(negedge aclk) begin
        if (sil.breakpoint_request === 1'b1 && sil.load_swi === 1'b1) begin
            n_req++;
        end
    end

    // ----------------------------------------
    // Register bus master
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check(rd_data, {24'h000000, exp});
        check({30'h0, rd_resp}, 32'h00000000);
    endtask : rchk

    // ----------------------------------------
    // CPU side helpers
    // ----------------------------------------
    task automatic go(input logic [15:0] pc, input logic w);
        @(posedge aclk);
        start_pc <= pc;
        load_pc <= 1'b1;
        run <= 1'b1;
        wait_mode <= w;
        @(posedge aclk);
        load_pc <= 1'b0;
    endtask : go

    task automatic wait_brk(input logic exp, input int maxc);
        for (int i = 0; i < maxc && sil.in_break !== exp; i++) @(negedge aclk);
        check({31'h0, sil.in_break}, {31'h0, exp});
    endtask : wait_brk

    task automatic quiet(input int n);
        repeat (n) @(negedge aclk);
        check({31'h0, sil.in_break}, 32'h00000000);
    endtask : quiet

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of every register, then an unmapped read
        for (int a = 0; a < 24; a += 4) rchk(8'(a), 8'h00);
        rd(8'h18);
        check({30'h0, rd_resp}, 32'h00000002);
        check(rd_data, 32'h00000000);
        wr(8'h18, 8'h55);
        check({30'h0, wr_resp}, 32'h00000002);
        s_axi_wstrb <= 4'hE;
        wr(8'h04, 8'hAA);
        s_axi_wstrb <= 4'hF;
        check({30'h0, wr_resp}, 32'h00000000);
        rchk(8'h04, 8'h00);
        check({31'h0, sil.in_break}, 32'h00000000);
        $display("test reset done");
        // Opcode address match
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h12);
        wr(8'h00, 8'h80);
        go(16'h0010, 1'b0);
        wait_brk(1'b1, 20);
        check({16'h0, sil.vector_addr}, 32'h0000FFFC);
        check({24'h0, sil.swi_opcode}, 32'h00000083);
        check({31'h0, sil.timer_halt}, 32'h00000001);
        check({31'h0, sil.flag_clear_allow}, 32'h00000000);
        check({31'h0, sil.watchdog_disable}, 32'h00000000);
        rchk(8'h00, 8'hC0);
        rchk(8'h04, 8'h00);
        rchk(8'h08, 8'h12);
        wr(8'h14, 8'h80);
        rchk(8'h14, 8'h80);
        check({31'h0, sil.flag_clear_allow}, 32'h00000001);
        wr(8'h00, 8'h80);
        wait_brk(1'b0, 60);
        check({31'h0, sil.timer_halt}, 32'h00000000);
        $display("test opcode match done");
        // Same address again after clearing active only
        go(16'h0010, 1'b0);
        quiet(30);
        $display("test repeat suppression done");
        // Operand match in monitor mode with watchdog disable
        @(posedge aclk);
        monitor_mode <= 1'b1;
        wr(8'h0C, 8'h01);
        wr(8'h08, 8'h15);
        go(16'h0010, 1'b0);
        wait_brk(1'b1, 30);
        check({16'h0, sil.vector_addr}, 32'h0000FEFC);
        check({31'h0, sil.watchdog_disable}, 32'h00000001);
        wr(8'h00, 8'h80);
        wait_brk(1'b0, 60);
        @(posedge aclk);
        monitor_mode <= 1'b0;
        wr(8'h0C, 8'h00);
        $display("test operand match done");
        // Enable cleared: no address break, then software break
        wr(8'h08, 8'h12);
        wr(8'h00, 8'h00);
        rchk(8'h00, 8'h00);
        go(16'h0010, 1'b0);
        quiet(20);
        wr(8'h00, 8'h40);
        wait_brk(1'b1, 20);
        rchk(8'h10, 8'h00);
        wr(8'h00, 8'h00);
        wait_brk(1'b0, 60);
        $display("test software break done");
        // Wait mode: enabled but no match, then break out of wait
        wr(8'h08, 8'h12);
        wr(8'h00, 8'h80);
        go(16'h0012, 1'b1);
        quiet(20);
        wr(8'h00, 8'hC0);
        wait_brk(1'b1, 20);
        rchk(8'h10, 8'h02);
        wr(8'h10, 8'h00);
        rchk(8'h10, 8'h00);
        wr(8'h00, 8'h00);
        wait_brk(1'b0, 60);
        $display("test wait exit done");
        check(n_req, 32'd4);
        complete_run();
    end
endmodule : tb_top
